// file: rtl/audio_path_config_decode.sv
/*
 * Configuration register bank of a voice record/playback path: two
 * 16-bit words loaded over a serial peripheral interface and decoded into
 * routing selects and power-down controls for the analog stages.
 * Assumes the host drives SCLK well below half the 100 MHz system clock,
 * and frames one word (register 1 only) or two words (register 0 then 1).
 */

// Function
// - Register 1 D10:D9 both zero routes the line input amp into the first mixer.
// - Register 1 D8:D7 = 01 selects mixer source only; 10 selects input source only.
// - Register 1 D4 selects filter input: zero first mixer, one storage playback.
// - Register 1 D1 zero powers the lowpass filter up.
// - Register 1 D3:D2 set filter band and rate: 8.0, 6.4, 5.3 kHz.
// - Register 1 D6:D5 = 10 feeds only the filter output to the second mixer.
// - The storage record input always comes from the second mixer output.
// - Register 1 D0 zero powers the automatic gain amplifier up.
// - Register 0 D9 zero routes the gain amplifier to the input-source path.
// - Register 1 D15:D14 = 01 routes second mixer output to the volume stage.
// - Register 0 D0 zero powers the volume attenuator up.
// - Register 1 D13:D11 pick one of eight attenuation steps; 011 gives 12 dB.
// - Register 0 D4:D3 both zero route the volume stage to the output.
// - Register 0 D2:D1 = 01 powers speaker up high gain, auxiliary down.
// - Both words go register 0 then 1; all apply on slave select rising.
module audio_path_config_decode (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Serial configuration port
    input  wire logic        SCLK,
    input  wire logic        SS_N,
    input  wire logic        MOSI,
    // Register readback
    output logic [15:0]      PATH_CONFIG_ZERO,
    output logic [15:0]      PATH_CONFIG_ONE,
    output logic             FRAME_ERROR,
    // First mixer routing
    output logic             LINE_INPUT_AMP_TO_MIXER_A,
    output logic [1:0]       MIXER_A_SRC,
    output logic             MIXER_A_TAKE_SRC,
    output logic             MIXER_A_TAKE_INSRC,
    output logic             MIXER_A_POWERDOWN,
    // Filter and rate
    output logic             FILTER_INPUT_SELECT,
    output logic             FILTER_POWERDOWN,
    output logic [1:0]       RATE_SEL,
    output logic             RATE_IS_8K0,
    output logic             RATE_IS_6K4,
    output logic             RATE_IS_5K3,
    // Second mixer and storage
    output logic             MIXER_B_TAKE_FILTER,
    output logic             MIXER_B_POWERDOWN,
    output logic             RECORD_FROM_MIXER_B,
    // Input side
    output logic             GAIN_STAGE_POWERDOWN,
    output logic             INPUT_SOURCE_SELECT,
    output logic             GAIN_TO_INPUT_SOURCE,
    // Volume and output
    output logic             VOLUME_FROM_MIXER_B,
    output logic [1:0]       VOLUME_SRC,
    output logic             VOLUME_POWERDOWN,
    output logic [2:0]       VOLUME_LEVEL,
    output logic             OUTPUT_FROM_VOLUME,
    output logic [1:0]       OUTPUT_SELECT,
    output logic             SPEAKER_ON,
    output logic             SPEAKER_HIGH_GAIN,
    output logic             AUX_OUT_ON
);

    // =========================================================================
    // State
    // =========================================================================
    typedef struct packed {
        logic [15:0] cfg_zero;
        logic [15:0] cfg_one;
        logic        frame_err;
        logic        line_to_mixa;
        logic [1:0]  mixa_src;
        logic        mixa_take_src;
        logic        mixa_take_insrc;
        logic        mixa_pd;
        logic        filt_in;
        logic        filt_pd;
        logic [1:0]  rate;
        logic        r8;
        logic        r6;
        logic        r5;
        logic        mixb_filt;
        logic        mixb_pd;
        logic        rec_mixb;
        logic        gain_pd;
        logic        in_src;
        logic        gain_to_src;
        logic        vol_mixb;
        logic [1:0]  vol_src;
        logic        vol_pd;
        logic [2:0]  vol_lev;
        logic        out_vol;
        logic [1:0]  out_sel;
        logic        spk_on;
        logic        spk_hi;
        logic        aux_on;
    } top_s;

    top_s state_reg;
    top_s state_next;

    logic [2:0]                                  pins_sync;
    logic                                        frame_done;
    logic [path_cfg_pkg::CNT_W-1:0]              frame_bits;
    logic [2*path_cfg_pkg::WORD_W-1:0]           frame_data;
    logic [15:0]                                 z;
    logic [15:0]                                 o;
    logic [1:0]                                  spk;
    logic                                        load;

    // =========================================================================
    // Pin capture and serial receiver
    // =========================================================================
    pin_sync #(
        .W (3)
    ) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   ({SCLK, SS_N, MOSI}),
        .q   (pins_sync)
    );

    cfg_shifter u_shift (
        .clk  (CLK),
        .rst  (RST),
        .sclk (pins_sync[2]),
        .ss_n (pins_sync[1]),
        .mosi (pins_sync[0]),
        .done (frame_done),
        .bits (frame_bits),
        .data (frame_data)
    );

    // =========================================================================
    // Register load and decode
    // =========================================================================
    // Words are committed only at the slave-select rising edge, so a half
    // shifted word never reaches the controls. A frame of the wrong length
    // is dropped whole and flagged rather than applied in part.
    always_comb
    begin
        state_next = state_reg;
        load       = 1'b0;
        z          = state_reg.cfg_zero;
        o          = state_reg.cfg_one;
        if (frame_done)
        begin
            if (frame_bits == path_cfg_pkg::TWO_WORDS)
            begin
                z    = frame_data[2*path_cfg_pkg::WORD_W-1:path_cfg_pkg::WORD_W];
                o    = frame_data[path_cfg_pkg::WORD_W-1:0];
                load = 1'b1;
                state_next.frame_err = 1'b0;
            end
            else if (frame_bits == path_cfg_pkg::ONE_WORD)
            begin
                o    = frame_data[path_cfg_pkg::WORD_W-1:0];
                load = 1'b1;
                state_next.frame_err = 1'b0;
            end
            else
                state_next.frame_err = 1'b1;
        end
        // Decode only on a load; decoded outputs hold otherwise.
        if (load)
        begin
            state_next.cfg_zero = z;
            state_next.cfg_one  = o;
            state_next.mixa_src = o[path_cfg_pkg::O_SRCA_LO +: 2];
            state_next.line_to_mixa =
                (o[path_cfg_pkg::O_SRCA_LO +: 2] == path_cfg_pkg::SRCA_LINE);
            state_next.mixa_take_src =
                (o[path_cfg_pkg::O_MIXA_LO +: 2] == path_cfg_pkg::MIXA_SRC);
            state_next.mixa_take_insrc =
                (o[path_cfg_pkg::O_MIXA_LO +: 2] == path_cfg_pkg::MIXA_INSRC);
            state_next.mixa_pd = &o[path_cfg_pkg::O_MIXA_LO +: 2];
            state_next.filt_in = o[path_cfg_pkg::O_FILT_IN];
            state_next.filt_pd = o[path_cfg_pkg::O_FILT_PD];
            state_next.rate    = o[path_cfg_pkg::O_RATE_LO +: 2];
            state_next.r8 = (o[path_cfg_pkg::O_RATE_LO +: 2] == path_cfg_pkg::RATE_8K0);
            state_next.r6 = (o[path_cfg_pkg::O_RATE_LO +: 2] == path_cfg_pkg::RATE_6K4);
            state_next.r5 = (o[path_cfg_pkg::O_RATE_LO +: 2] == path_cfg_pkg::RATE_5K3);
            state_next.mixb_filt =
                (o[path_cfg_pkg::O_MIXB_LO +: 2] == path_cfg_pkg::MIXB_FILT);
            state_next.mixb_pd = &o[path_cfg_pkg::O_MIXB_LO +: 2];
            state_next.gain_pd = o[path_cfg_pkg::O_GAIN_PD];
            state_next.in_src  = z[path_cfg_pkg::Z_IN_SRC];
            state_next.gain_to_src = !z[path_cfg_pkg::Z_IN_SRC];
            state_next.vol_src = o[path_cfg_pkg::O_VSRC_LO +: 2];
            state_next.vol_mixb =
                (o[path_cfg_pkg::O_VSRC_LO +: 2] == path_cfg_pkg::VSRC_MIXB);
            state_next.vol_pd  = z[path_cfg_pkg::Z_VOL_PD];
            state_next.vol_lev = o[path_cfg_pkg::O_VLEV_LO +: 3];
            state_next.out_sel = z[path_cfg_pkg::Z_OUT_LO +: 2];
            state_next.out_vol =
                (z[path_cfg_pkg::Z_OUT_LO +: 2] == path_cfg_pkg::OUT_VOLUME);
        end
        // Speaker and auxiliary controls follow the stored register 0 field.
        spk = state_next.cfg_zero[path_cfg_pkg::Z_SPK_LO +: 2];
        state_next.spk_on = (spk == path_cfg_pkg::SPK_HIGH);
        state_next.spk_hi = (spk == path_cfg_pkg::SPK_HIGH);
        state_next.aux_on = (spk != path_cfg_pkg::SPK_HIGH) && (spk != 2'h3);
        state_next.rec_mixb = 1'b1;
    end

    // Reset leaves every stage powered down and decoded to match.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg          <= '0;
            state_reg.cfg_zero <= path_cfg_pkg::CFG_RST;
            state_reg.cfg_one  <= path_cfg_pkg::CFG_RST;
            state_reg.mixa_src <= 2'h3;
            state_reg.mixa_pd  <= 1'b1;
            state_reg.filt_in  <= 1'b1;
            state_reg.filt_pd  <= 1'b1;
            state_reg.rate     <= 2'h3;
            state_reg.mixb_pd  <= 1'b1;
            state_reg.rec_mixb <= 1'b1;
            state_reg.gain_pd  <= 1'b1;
            state_reg.in_src   <= 1'b1;
            state_reg.vol_src  <= 2'h3;
            state_reg.vol_pd   <= 1'b1;
            state_reg.vol_lev  <= 3'h7;
            state_reg.out_sel  <= 2'h3;
        end
        else
            state_reg <= state_next;
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    assign PATH_CONFIG_ZERO          = state_reg.cfg_zero;
    assign PATH_CONFIG_ONE           = state_reg.cfg_one;
    assign FRAME_ERROR               = state_reg.frame_err;
    assign LINE_INPUT_AMP_TO_MIXER_A = state_reg.line_to_mixa;
    assign MIXER_A_SRC               = state_reg.mixa_src;
    assign MIXER_A_TAKE_SRC          = state_reg.mixa_take_src;
    assign MIXER_A_TAKE_INSRC        = state_reg.mixa_take_insrc;
    assign MIXER_A_POWERDOWN         = state_reg.mixa_pd;
    assign FILTER_INPUT_SELECT       = state_reg.filt_in;
    assign FILTER_POWERDOWN          = state_reg.filt_pd;
    assign RATE_SEL                  = state_reg.rate;
    assign RATE_IS_8K0               = state_reg.r8;
    assign RATE_IS_6K4               = state_reg.r6;
    assign RATE_IS_5K3               = state_reg.r5;
    assign MIXER_B_TAKE_FILTER       = state_reg.mixb_filt;
    assign MIXER_B_POWERDOWN         = state_reg.mixb_pd;
    assign RECORD_FROM_MIXER_B       = state_reg.rec_mixb;
    assign GAIN_STAGE_POWERDOWN      = state_reg.gain_pd;
    assign INPUT_SOURCE_SELECT       = state_reg.in_src;
    assign GAIN_TO_INPUT_SOURCE      = state_reg.gain_to_src;
    assign VOLUME_FROM_MIXER_B       = state_reg.vol_mixb;
    assign VOLUME_SRC                = state_reg.vol_src;
    assign VOLUME_POWERDOWN          = state_reg.vol_pd;
    assign VOLUME_LEVEL              = state_reg.vol_lev;
    assign OUTPUT_FROM_VOLUME        = state_reg.out_vol;
    assign OUTPUT_SELECT             = state_reg.out_sel;
    assign SPEAKER_ON                = state_reg.spk_on;
    assign SPEAKER_HIGH_GAIN         = state_reg.spk_hi;
    assign AUX_OUT_ON                = state_reg.aux_on;

endmodule

// file: rtl/path_cfg_pkg.sv
/*
 * Constants shared by the audio path configuration block: frame layout,
 * field positions within the two 16-bit configuration words, and the
 * enumerations of the decoded selects.
 * Assumes a single 100 MHz system clock and a host that frames each
 * configuration word with slave select low, MSB first.
 */
package path_cfg_pkg;

    // =========================================================================
    // Frame and word layout
    // =========================================================================
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CNT_W       = 6;
    localparam logic [CNT_W-1:0] ONE_WORD  = 6'h10;
    localparam logic [CNT_W-1:0] TWO_WORDS = 6'h20;
    localparam logic [WORD_W-1:0] CFG_RST  = 16'hFFFF;

    // =========================================================================
    // Configuration register 0 fields
    // =========================================================================
    localparam int unsigned Z_VOL_PD    = 0;
    localparam int unsigned Z_SPK_LO    = 1;
    localparam int unsigned Z_OUT_LO    = 3;
    localparam int unsigned Z_IN_SRC    = 9;

    // =========================================================================
    // Configuration register 1 fields
    // =========================================================================
    localparam int unsigned O_GAIN_PD   = 0;
    localparam int unsigned O_FILT_PD   = 1;
    localparam int unsigned O_RATE_LO   = 2;
    localparam int unsigned O_FILT_IN   = 4;
    localparam int unsigned O_MIXB_LO   = 5;
    localparam int unsigned O_MIXA_LO   = 7;
    localparam int unsigned O_SRCA_LO   = 9;
    localparam int unsigned O_VLEV_LO   = 11;
    localparam int unsigned O_VSRC_LO   = 14;

    // =========================================================================
    // Encodings
    // =========================================================================
    localparam logic [1:0] SRCA_LINE    = 2'h0;
    localparam logic [1:0] MIXA_SRC     = 2'h1;
    localparam logic [1:0] MIXA_INSRC   = 2'h2;
    localparam logic [1:0] MIXB_FILT    = 2'h2;
    localparam logic [1:0] VSRC_MIXB    = 2'h1;
    localparam logic [1:0] OUT_VOLUME   = 2'h0;
    localparam logic [1:0] SPK_HIGH     = 2'h1;

    typedef enum logic [1:0] {RATE_8K0, RATE_6K4, RATE_5K3, RATE_RSV} rate_e;

endpackage

// file: rtl/pin_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes the inputs are plain levels; nothing outside reads the first stage.
 */
module pin_sync #(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    // =========================================================================
    // Stages
    // =========================================================================
    // The second stage reads only the first, keeping metastability contained.
    always_comb
    begin
        state_next    = state_reg;
        state_next.s1 = d;
        state_next.s2 = state_reg.s1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign q = state_reg.s2;

endmodule

// file: rtl/cfg_shifter.sv
/*
 * Serial receiver for configuration frames. Shifts MOSI in MSB first on
 * synchronised SCLK rising edges while slave select is low, and reports
 * the frame when slave select rises.
 * Assumes synchronised pin levels from the same clock domain.
 */
module cfg_shifter (
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    // Synchronised pins
    input  wire logic                                  sclk,
    input  wire logic                                  ss_n,
    input  wire logic                                  mosi,
    // Frame result
    output logic                                       done,
    output logic [path_cfg_pkg::CNT_W-1:0]             bits,
    output logic [2*path_cfg_pkg::WORD_W-1:0]          data
);

    typedef struct packed {
        logic                                    sclk_d;
        logic                                    ss_d;
        logic [path_cfg_pkg::CNT_W-1:0]          cnt;
        logic [2*path_cfg_pkg::WORD_W-1:0]       sh;
        logic                                    done;
    } shift_s;

    shift_s state_reg;
    shift_s state_next;

    // =========================================================================
    // Shift and frame end
    // =========================================================================
    // The count saturates so that an overlong frame is seen as malformed.
    always_comb
    begin
        state_next        = state_reg;
        state_next.sclk_d = sclk;
        state_next.ss_d   = ss_n;
        state_next.done   = 1'b0;
        if (!ss_n && sclk && !state_reg.sclk_d)
        begin
            state_next.sh = {state_reg.sh[2*path_cfg_pkg::WORD_W-2:0], mosi};
            if (state_reg.cnt != {path_cfg_pkg::CNT_W{1'b1}})
                state_next.cnt = state_reg.cnt + 1'b1;
        end
        if (ss_n && !state_reg.ss_d)
            state_next.done = 1'b1;
        if (!ss_n && state_reg.ss_d)
            state_next.cnt = '0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg      <= '0;
            state_reg.ss_d <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    assign done = state_reg.done;
    assign bits = state_reg.cnt;
    assign data = state_reg.sh;

endmodule

// file: dv/audio_path_config_decode_checker.sv
/*
 * Port checks of the audio path configuration block.
 * Assumes one clock and a synchronous active-high reset.
 */
module audio_path_config_decode_checker (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Select and words
    input wire logic        SS_N,
    input wire logic [15:0] PATH_CONFIG_ZERO,
    input wire logic [15:0] PATH_CONFIG_ONE,
    // Decoded controls
    input wire logic        LINE_INPUT_AMP_TO_MIXER_A,
    input wire logic        MIXER_A_TAKE_SRC,
    input wire logic        MIXER_A_TAKE_INSRC,
    input wire logic        FILTER_INPUT_SELECT,
    input wire logic        FILTER_POWERDOWN,
    input wire logic        RATE_IS_8K0,
    input wire logic        RATE_IS_6K4,
    input wire logic        RATE_IS_5K3,
    input wire logic        MIXER_B_TAKE_FILTER,
    input wire logic        RECORD_FROM_MIXER_B,
    input wire logic        GAIN_STAGE_POWERDOWN,
    input wire logic        GAIN_TO_INPUT_SOURCE,
    input wire logic        VOLUME_FROM_MIXER_B,
    input wire logic        VOLUME_POWERDOWN,
    input wire logic [2:0]  VOLUME_LEVEL,
    input wire logic        OUTPUT_FROM_VOLUME,
    input wire logic        SPEAKER_ON,
    input wire logic        SPEAKER_HIGH_GAIN,
    input wire logic        AUX_OUT_ON
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // =========================================================================
    // Decode
    // =========================================================================
    AST_LINE_AMP: assert property (LINE_INPUT_AMP_TO_MIXER_A == (PATH_CONFIG_ONE[10:9] == 2'h0))
        else $error("line amp");
    AST_MIXER_A: assert property ({MIXER_A_TAKE_SRC, MIXER_A_TAKE_INSRC} ==
        {PATH_CONFIG_ONE[8:7] == 2'h1, PATH_CONFIG_ONE[8:7] == 2'h2})
        else $error("mixer a");
    AST_FILTER_IN: assert property (FILTER_INPUT_SELECT == PATH_CONFIG_ONE[4])
        else $error("filter in");
    AST_FILTER_PD: assert property (!PATH_CONFIG_ONE[1] |-> !FILTER_POWERDOWN)
        else $error("filter pd");
    AST_RATE: assert property ((PATH_CONFIG_ONE[3:2] == 2'h1) |-> RATE_IS_6K4 && !RATE_IS_8K0
        && !RATE_IS_5K3)
        else $error("rate");
    AST_MIXER_B: assert property (MIXER_B_TAKE_FILTER == (PATH_CONFIG_ONE[6:5] == 2'h2))
        else $error("mixer b");
    AST_RECORD: assert property (RECORD_FROM_MIXER_B)
        else $error("record");
    AST_GAIN_PD: assert property (GAIN_STAGE_POWERDOWN == PATH_CONFIG_ONE[0])
        else $error("gain pd");
    AST_GAIN_ROUTE: assert property (GAIN_TO_INPUT_SOURCE != PATH_CONFIG_ZERO[9])
        else $error("gain route");
    AST_VOL_SRC: assert property (VOLUME_FROM_MIXER_B == (PATH_CONFIG_ONE[15:14] == 2'h1))
        else $error("volume src");
    AST_VOL_PD: assert property (VOLUME_POWERDOWN == PATH_CONFIG_ZERO[0])
        else $error("volume pd");
    AST_VOL_LEVEL: assert property (VOLUME_LEVEL == PATH_CONFIG_ONE[13:11])
        else $error("volume level");
    AST_OUTPUT: assert property (OUTPUT_FROM_VOLUME == (PATH_CONFIG_ZERO[4:3] == 2'h0))
        else $error("output");
    AST_SPEAKER: assert property ((PATH_CONFIG_ZERO[2:1] == 2'h1) |-> SPEAKER_ON
        && SPEAKER_HIGH_GAIN && !AUX_OUT_ON)
        else $error("speaker");

    // =========================================================================
    // Update timing
    // =========================================================================
    AST_HOLD: assert property (!$stable(PATH_CONFIG_ZERO) || !$stable(PATH_CONFIG_ONE)
        |-> $past(SS_N, 3) && !$past(SS_N, 6))
        else $error("words moved outside an update");
endmodule

// Every checker port has a design port of the same name.
bind audio_path_config_decode audio_path_config_decode_checker checker_inst (.*);

// file: dv/spi_host_model.sv
/*
 * Host model of the serial port: frames words MSB first.
 * Assumes pacing by CLK; SCLK idles low between frames.
 */
module spi_host_model (
    // Pacing clock
    input wire logic CLK,
    // Serial configuration pins
    output logic     SCLK,
    output logic     SS_N,
    output logic     MOSI
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins at time zero.
    initial
    begin
        SCLK = 1'b0;
        SS_N = 1'b1;
        MOSI = 1'b0;
    end

    // One frame of n bits, half clocks per SCLK phase.
    task automatic send(input logic [31:0] d, input int n, input int half);
        @(posedge CLK);
        #1 SS_N = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            MOSI = d[i];
            repeat (half) @(posedge CLK);
            #1 SCLK = 1'b1;
            repeat (half) @(posedge CLK);
            #1 SCLK = 1'b0;
        end
        repeat (half) @(posedge CLK);
        #1 SS_N = 1'b1;
        // A deselected data line must not look like the last bit.
        MOSI = ~MOSI;
    endtask
endmodule

// file: dv/test_audio_path_config_decode.sv
/*
 * Bench of the audio path configuration block.
 * Assumes the host model and the bound checker.
 */
module test_audio_path_config_decode;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, sclk, ss_n, mosi, frame_error;
    logic [15:0] cfg_zero, cfg_one, e0, e1;
    logic        line_amp, take_src, take_insrc, filt_sel, filt_pd, r8k0, r6k4, r5k3;
    logic        mixb_filt, rec_b, gain_pd, gain_in, vol_b, vol_pd, out_vol;
    logic        spk_on, spk_hg, aux_on;
    logic [2:0]  vol_lev;
    int          num_errors = 0, comparisons = 0;

    // =========================================================================
    // Clock, design and host
    // =========================================================================
    initial clk = 1'b0;
    always #5 clk = ~clk;

    audio_path_config_decode DUT (
        .CLK(clk), .RST(rst), .SCLK(sclk), .SS_N(ss_n), .MOSI(mosi),
        .PATH_CONFIG_ZERO(cfg_zero), .PATH_CONFIG_ONE(cfg_one), .FRAME_ERROR(frame_error),
        .LINE_INPUT_AMP_TO_MIXER_A(line_amp), .MIXER_A_SRC(), .MIXER_A_TAKE_SRC(take_src),
        .MIXER_A_TAKE_INSRC(take_insrc), .MIXER_A_POWERDOWN(), .FILTER_INPUT_SELECT(filt_sel),
        .FILTER_POWERDOWN(filt_pd), .RATE_SEL(), .RATE_IS_8K0(r8k0), .RATE_IS_6K4(r6k4),
        .RATE_IS_5K3(r5k3), .MIXER_B_TAKE_FILTER(mixb_filt), .MIXER_B_POWERDOWN(),
        .RECORD_FROM_MIXER_B(rec_b), .GAIN_STAGE_POWERDOWN(gain_pd), .INPUT_SOURCE_SELECT(),
        .GAIN_TO_INPUT_SOURCE(gain_in), .VOLUME_FROM_MIXER_B(vol_b), .VOLUME_SRC(),
        .VOLUME_POWERDOWN(vol_pd), .VOLUME_LEVEL(vol_lev), .OUTPUT_FROM_VOLUME(out_vol),
        .OUTPUT_SELECT(), .SPEAKER_ON(spk_on), .SPEAKER_HIGH_GAIN(spk_hg), .AUX_OUT_ON(aux_on)
    );

    spi_host_model host (.CLK(clk), .SCLK(sclk), .SS_N(ss_n), .MOSI(mosi));

    // =========================================================================
    // Checking
    // =========================================================================
    // Speaker code 11 is all off.
    function automatic logic [15:0] spk_exp(input logic [1:0] c);
        return {13'h0, c == 2'h1, c == 2'h1, c == 2'h0 || c == 2'h2};
    endfunction

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Every connected output.
    task automatic check_all(input logic fe);
        cmp("word zero", e0, cfg_zero);
        cmp("word one", e1, cfg_one);
        cmp("frame error", 16'(fe), 16'(frame_error));
        cmp("line amp", 16'(e1[10:9] == 2'h0), 16'(line_amp));
        cmp("mixer a", {14'h0, e1[8:7] == 2'h1, e1[8:7] == 2'h2}, {14'h0, take_src, take_insrc});
        cmp("filter in", 16'(e1[4]), 16'(filt_sel));
        cmp("filter pd", 16'(e1[1]), 16'(filt_pd));
        cmp("rate", {13'h0, e1[3:2] == 2'h0, e1[3:2] == 2'h1, e1[3:2] == 2'h2},
            {13'h0, r8k0, r6k4, r5k3});
        cmp("mixer b", 16'(e1[6:5] == 2'h2), 16'(mixb_filt));
        cmp("record", 16'h0001, 16'(rec_b));
        cmp("gain pd", 16'(e1[0]), 16'(gain_pd));
        cmp("gain route", 16'(!e0[9]), 16'(gain_in));
        cmp("volume src", 16'(e1[15:14] == 2'h1), 16'(vol_b));
        cmp("volume pd", 16'(e0[0]), 16'(vol_pd));
        cmp("volume level", 16'(e1[13:11]), 16'(vol_lev));
        cmp("output", 16'(e0[4:3] == 2'h0), 16'(out_vol));
        cmp("speaker", spk_exp(e0[2:1]), {13'h0, spk_on, spk_hg, aux_on});
    endtask

    // A good frame; a single word always goes to register one.
    task automatic frame(input logic [15:0] z, o, input logic two, input int half);
        if (two)
            host.send({z, o}, 32, half);
        else
            host.send({16'h0, o}, 16, half);
        if (two)
            e0 = z;
        e1 = o;
        repeat (8) @(posedge clk);
        #1 check_all(1'b0);
    endtask

    // Wrong length: decoded outputs hold, frame error set.
    task automatic bad(input int n, input int half);
        host.send($urandom, n, half);
        repeat (8) @(posedge clk);
        #1 check_all(1'b1);
    endtask

    // =========================================================================
    // Sequence
    // =========================================================================
    initial
    begin
        logic [15:0] z, o;
        rst = 1'b1;
        e0 = 16'hFFFF;
        e1 = 16'hFFFF;
        void'($urandom(32'h72EA));
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1 check_all(1'b0);
        // Worked mode settings.
        frame(16'h440B, 16'h01E3, 1'b1, 3);
        frame(16'h440B, 16'h00C5, 1'b0, 3);
        frame(16'h2421, 16'h0148, 1'b1, 6);
        frame(16'h2421, 16'h59D1, 1'b1, 4);
        bad(15, 3);
        bad(17, 3);
        bad(31, 4);
        bad(1, 3);
        // Random; a new word zero needs both words.
        for (int i = 0; i < 24; i++)
        begin
            z = $urandom_range(1) ? e0 : 16'($urandom);
            o = 16'($urandom);
            frame(z, o, (z != e0) || $urandom_range(1), $urandom_range(6, 3));
        end
        // Mid-run reset.
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        e0 = 16'hFFFF;
        e1 = 16'hFFFF;
        repeat (3) @(posedge clk);
        #1 check_all(1'b0);
        frame(16'h0000, 16'h0000, 1'b1, 3);
        print_verdict;
    end

    // Watchdog.
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
endmodule
